/* File: chip_select_generator.sv */
// Summary of operation
// - Field code 00 discrete, 01 alternate, 10 select 8-bit, 11 select 16-bit.
// - Boot pin is always a chip select whatever its field holds.
// - High pin-assign register has five fields; bits 15:10 read zero.
// - Fields drive selects six to ten, address 19-23 or latch bits, E-clock.
// - Reset sets each field low bit, high bit from a strapped data line.
// - Base register bits 15:3 hold the block's lowest address bits 23:11.
// - Block size code sets size from 2K to 1M and bits compared.
// - Boot channel uses same layout but resets to another block size.
// - Mode 0 asynchronous, 1 synchronous; no autovector in synchronous mode.
// - Byte option gates assertion: off, lower, upper or both lanes.
// - Direction option: reads, writes or both; code 00 reserved.
// - Strobe option times assertion on address or data strobe.
// - Acknowledge code: 0-13 waits, fast termination, or external acknowledge.
// - Space option: CPU, user, supervisor, or user or supervisor.
// - Level option matches all or one acknowledge level.
// - Autovector bit requests internal autovector on matching acknowledge.
// - Discrete pins drive the output latch value, except the top pin, which drives the E-clock.
module chip_select_generator
	import chip_select_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [23:0] busAddr,
	input wire logic busRead,
	input wire logic busUpper,
	input wire logic busLower,
	input wire logic [1:0] busSpace,
	input wire logic [2:0] busLevel,
	input wire logic cycleValid,
	input wire logic addrStrobe,
	input wire logic dataStrobe,
	input wire logic ePhaseClock,
	input wire logic externalAck,
	input wire logic [13:0] lowAssign,
	input wire logic [STRAP_W-1:0] resetStrap,
	input wire logic [NUM_LATCH-1:0] discreteOutputLatch,
	output logic bootSelectPinN,
	output logic [5:0] lowSelectN,
	output logic [NUM_HIGH-1:0] pinLevel,
	output logic cycleAck,
	output logic ackPort16,
	output logic fastTerm,
	output logic awaitExternal,
	output logic autovector,
	output logic syncCycle
);
	logic [9:0] pinAssign_ff;
	logic [15:0] base_ff [NUM_SEL];
	logic [15:0] opt_ff [NUM_SEL];
	logic [31:0] prdata_ff;
	logic [NUM_SEL-1:0] selN_ff;
	logic [NUM_HIGH-1:0] pinLevel_ff;
	logic [STRAP_W-1:0] strapS1_ff, strapS2_ff, strapS3_ff, strapStable_ff;
	logic extS1_ff, extS2_ff, extS3_ff, extStable_ff;
	logic cycleValid_ff;
	logic winPort16_ff, fast_ff, external_ff, autovec_ff, sync_ff;
	logic [1:0] assignCode [NUM_SEL];
	logic [NUM_SEL-1:0] rawHit, hit, strobeOk, assertNow;
	logic [3:0] winIdx;
	logic anyHit, startPulse, timerStart, timerAck, fastNow;
	logic [15:0] winOpt;
	logic [3:0] winAck;
	logic access, slotOk;
	logic [4:0] slot;
	logic [3:0] chanOf;

	function automatic logic [3:0] chanOfSlot(input logic [4:0] s);
		logic [4:0] d;
		d = s - SLOT_FIRST_SEL;
		chanOfSlot = d[4:1];
	endfunction

	// APB slave: zero wait states; read data staged during the setup cycle
	assign access = psel & penable;
	assign slot = paddr[6:2];
	assign slotOk = paddr[1:0] == 2'h0 && paddr <= OFF_LAST;
	assign chanOf = chanOfSlot(slot);
	assign pready = 1'b1;
	assign pslverr = access & (~slotOk | (pwrite & paddr == OFF_STATUS));
	assign prdata = prdata_ff;

	always_ff @(posedge clk) begin
		if (reset) begin
			prdata_ff <= 32'h0000_0000;
		end else if (psel & ~penable & ~pwrite) begin
			if (!slotOk) prdata_ff <= 32'h0000_0000;
			else if (paddr == OFF_PIN_ASSIGN)
				prdata_ff <= {22'h00_0000, pinAssign_ff};
			else if (paddr == OFF_STATUS)
				prdata_ff <= {19'h0_0000, external_ff, ~selN_ff};
			else if (slot[0])
				prdata_ff <= {16'h0000, opt_ff[chanOf]};
			else
				prdata_ff <= {16'h0000, base_ff[chanOf]};
		end
	end

	// Reset strap: three flops, accepted once the last two agree
	always_ff @(posedge clk) begin
		strapS1_ff <= resetStrap;
		strapS2_ff <= strapS1_ff;
		strapS3_ff <= strapS2_ff;
		if (strapS2_ff == strapS3_ff) strapStable_ff <= strapS3_ff;
	end

	always_ff @(posedge clk) begin
		extS1_ff <= externalAck;
		extS2_ff <= extS1_ff;
		extS3_ff <= extS2_ff;
		if (extS2_ff == extS3_ff) extStable_ff <= extS3_ff;
	end

	// Strap is sampled on every reset cycle, so the final reset edge wins
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < NUM_HIGH; i++) begin
				pinAssign_ff[2*i] <= 1'b1;
				pinAssign_ff[2*i+1] <= strapStable_ff[i];
			end
		end else if (access & pwrite & slotOk & paddr == OFF_PIN_ASSIGN) begin
			pinAssign_ff <= pwdata[9:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			for (int k = 0; k < NUM_SEL; k++) begin
				base_ff[k] <= (k == 0) ? BOOT_BASE_RST : SEL_REG_RST;
				opt_ff[k] <= SEL_REG_RST;
			end
		end else if (access & pwrite & slotOk & slot >= SLOT_FIRST_SEL) begin
			if (slot[0]) opt_ff[chanOf] <= pwdata[15:0];
			else base_ff[chanOf] <= pwdata[15:0];
		end
	end

	// Index 0 is boot, 1..6 channels 0..5, 7..11 the multiplexed pins
	always_comb begin
		assignCode[0] = {1'b1, lowAssign[0]};
		for (int i = 0; i < 6; i++)
			assignCode[i+1] = lowAssign[2*i+3 -: 2];
		for (int i = 0; i < NUM_HIGH; i++)
			assignCode[i+7] = pinAssign_ff[2*i+1 -: 2];
	end

	genvar g;
	generate
		for (g = 0; g < NUM_SEL; g++) begin : gen_sel
			cs_channel_match u_match (
				.baseReg(base_ff[g]),
				.optReg(opt_ff[g]),
				.busAddr(busAddr),
				.busRead(busRead),
				.busUpper(busUpper),
				.busLower(busLower),
				.busSpace(busSpace),
				.busLevel(busLevel),
				.hit(rawHit[g])
			);
			assign hit[g] = rawHit[g] & assignCode[g][1];
			// Synchronous mode also waits for the E phase
			assign strobeOk[g] = (opt_ff[g][STROBE_BIT] ? dataStrobe
				: addrStrobe) & (~opt_ff[g][MODE_BIT] | ePhaseClock);
			assign assertNow[g] = cycleValid & hit[g] & strobeOk[g];
		end
	endgenerate

	always_ff @(posedge clk) begin
		if (reset) selN_ff <= {NUM_SEL{1'b1}};
		else selN_ff <= ~assertNow;
	end

	assign bootSelectPinN = selN_ff[0];
	assign lowSelectN = selN_ff[6:1];

	// Lowest index wins when windows overlap; boot first
	always_comb begin
		winIdx = 4'h0;
		anyHit = 1'b0;
		for (int k = NUM_SEL - 1; k >= 0; k--) begin
			if (hit[k]) begin
				winIdx = 4'(k);
				anyHit = 1'b1;
			end
		end
	end

	assign winOpt = opt_ff[winIdx];
	assign winAck = winOpt[ACK_HI:ACK_LO];
	assign startPulse = cycleValid & ~cycleValid_ff & anyHit;
	assign timerStart = startPulse & ~winOpt[MODE_BIT] &
		winAck <= ACK_LAST_WAIT;
	assign fastNow = startPulse & ~winOpt[MODE_BIT] & winAck == ACK_FAST;

	cs_wait_timer u_timer (
		.clk(clk),
		.reset(reset),
		.start(timerStart),
		.waitCount(winAck),
		.cycleValid(cycleValid),
		.ackPulse(timerAck)
	);

	// Fast termination acknowledges in the cycle that opens the access
	assign cycleAck = timerAck | fastNow;
	assign ackPort16 = winPort16_ff;
	assign fastTerm = fast_ff;
	assign awaitExternal = external_ff;
	assign autovector = autovec_ff;
	assign syncCycle = sync_ff;

	always_ff @(posedge clk) begin
		if (reset) cycleValid_ff <= 1'b0;
		else cycleValid_ff <= cycleValid;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			winPort16_ff <= 1'b0;
			fast_ff <= 1'b0;
			sync_ff <= 1'b0;
		end else if (startPulse) begin
			winPort16_ff <= assignCode[winIdx][0];
			fast_ff <= winAck == ACK_FAST & ~winOpt[MODE_BIT];
			sync_ff <= winOpt[MODE_BIT];
		end else if (!cycleValid) begin
			fast_ff <= 1'b0;
			sync_ff <= 1'b0;
		end
	end

	// External acknowledge wait ends when the synchronised pin answers
	always_ff @(posedge clk) begin
		if (reset) external_ff <= 1'b0;
		else if (startPulse)
			external_ff <= winAck == ACK_EXTERNAL & ~winOpt[MODE_BIT];
		else if (!cycleValid || extStable_ff) external_ff <= 1'b0;
	end

	// Synchronous cycles never autovector, even if software sets both
	always_ff @(posedge clk) begin
		if (reset) autovec_ff <= 1'b0;
		else if (startPulse)
			autovec_ff <= busSpace == SPACE_CPU & winOpt[AUTOVEC_BIT] &
				~winOpt[MODE_BIT];
		else if (!cycleValid) autovec_ff <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			pinLevel_ff <= {NUM_HIGH{1'b1}};
		end else begin
			for (int i = 0; i < NUM_HIGH; i++) begin
				unique case (assignCode[i+7])
					PA_DISCRETE: pinLevel_ff[i] <= (i < NUM_LATCH) ?
						discreteOutputLatch[i % NUM_LATCH] : ePhaseClock;
					PA_ALTERNATE: pinLevel_ff[i] <= busAddr[ALT_ADDR_LO+i];
					PA_SEL8, PA_SEL16: pinLevel_ff[i] <= ~assertNow[i+7];
				endcase
			end
		end
	end

	assign pinLevel = pinLevel_ff;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	AST_DISCRETE_PIN: assert property (
		assignCode[7] == PA_DISCRETE |=>
		pinLevel[0] == $past(discreteOutputLatch[0]))
		else $error("discrete pin does not follow latch bit");
	AST_EPHASE_PIN: assert property (
		assignCode[11] == PA_DISCRETE |=> pinLevel[4] == $past(ePhaseClock))
		else $error("top pin does not carry the E phase clock");
	AST_ALT_PIN: assert property (
		assignCode[8] == PA_ALTERNATE |=> pinLevel[1] == $past(busAddr[20]))
		else $error("alternate pin does not carry its address bit");
	AST_UPPER_ZERO: assert property (
		psel && penable && !pwrite && paddr == OFF_PIN_ASSIGN |->
		prdata[31:10] == 22'h00_0000)
		else $error("pin assignment upper bits read nonzero");
	AST_RESET_LOW_ONES: assert property (
		$fell(reset) |-> (pinAssign_ff & PIN_ASSIGN_LOW_ONES) ==
		PIN_ASSIGN_LOW_ONES)
		else $error("field low bits not set by reset");
	AST_BYTE_OFF: assert property (
		opt_ff[1][BYTE_HI:BYTE_LO] == 2'h0 |=> selN_ff[1])
		else $error("select asserted with byte option disabled");
	AST_READ_ONLY: assert property (
		opt_ff[1][RW_HI:RW_LO] == 2'h1 && !busRead |=> selN_ff[1])
		else $error("read-only select asserted on a write");
	AST_SPACE_SUPV: assert property (
		opt_ff[1][SPACE_HI:SPACE_LO] == SPACE_SUPV &&
		busSpace == SPACE_USER |=> selN_ff[1])
		else $error("supervisor select asserted in user space");
	AST_STROBE_DATA: assert property (
		opt_ff[1][STROBE_BIT] && !dataStrobe |=> selN_ff[1])
		else $error("data strobe select asserted without data strobe");
	AST_UNASSIGNED: assert property (
		!assignCode[7][1] |=> selN_ff[7])
		else $error("select asserted on a pin not assigned as select");
	AST_PORT_SIZE: assert property (
		startPulse |=> ackPort16 == $past(assignCode[winIdx][0]))
		else $error("port size does not follow the winning field");
	AST_NO_SYNC_AUTOVEC: assert property (
		sync_ff |-> !autovector)
		else $error("autovector given in synchronous mode");

	COV_BOOT_SELECT: cover property (!selN_ff[0]);
	COV_ALT_PIN: cover property (assignCode[11] == PA_ALTERNATE);
	COV_AUTOVEC: cover property (autovector);
	COV_FAST: cover property (fastNow);
endmodule // chip_select_generator

/* File: chip_select_pkg.sv */
package chip_select_pkg;
	localparam int NUM_SEL = 12;
	localparam int NUM_HIGH = 5;
	localparam int NUM_LATCH = 4;
	localparam int STRAP_W = 5;
	localparam logic [11:0] OFF_PIN_ASSIGN = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_BOOT_BASE = 12'h008;
	localparam logic [11:0] OFF_BOOT_OPT = 12'h00C;
	localparam logic [11:0] OFF_LAST = 12'h064;
	localparam logic [4:0] SLOT_FIRST_SEL = 5'h02;
	localparam logic [15:0] BOOT_BASE_RST = 16'h0007;
	localparam logic [15:0] SEL_REG_RST = 16'h0000;
	localparam logic [9:0] PIN_ASSIGN_LOW_ONES = 10'h155;
	localparam int MODE_BIT = 15;
	localparam int BYTE_HI = 14;
	localparam int BYTE_LO = 13;
	localparam int RW_HI = 12;
	localparam int RW_LO = 11;
	localparam int STROBE_BIT = 10;
	localparam int ACK_HI = 9;
	localparam int ACK_LO = 6;
	localparam int SPACE_HI = 5;
	localparam int SPACE_LO = 4;
	localparam int LEVEL_HI = 3;
	localparam int LEVEL_LO = 1;
	localparam int AUTOVEC_BIT = 0;
	localparam int BASE_HI = 15;
	localparam int BASE_LO = 3;
	localparam int BLK_HI = 2;
	localparam int BLK_LO = 0;
	localparam int ALT_ADDR_LO = 19;
	localparam logic [1:0] PA_DISCRETE = 2'h0;
	localparam logic [1:0] PA_ALTERNATE = 2'h1;
	localparam logic [1:0] PA_SEL8 = 2'h2;
	localparam logic [1:0] PA_SEL16 = 2'h3;
	localparam logic [3:0] ACK_LAST_WAIT = 4'hD;
	localparam logic [3:0] ACK_FAST = 4'hE;
	localparam logic [3:0] ACK_EXTERNAL = 4'hF;
	localparam logic [1:0] SPACE_CPU = 2'h0;
	localparam logic [1:0] SPACE_USER = 2'h1;
	localparam logic [1:0] SPACE_SUPV = 2'h2;
	localparam logic [1:0] SPACE_BOTH = 2'h3;
	localparam logic [2:0] LEVEL_ALL = 3'h0;

	function automatic logic [12:0] blockMask(input logic [2:0] size);
		case (size)
			3'h0: blockMask = 13'h1FFF;
			3'h1: blockMask = 13'h1FFC;
			3'h2: blockMask = 13'h1FF8;
			3'h3: blockMask = 13'h1FE0;
			3'h4: blockMask = 13'h1FC0;
			3'h5: blockMask = 13'h1F80;
			3'h6: blockMask = 13'h1F00;
			default: blockMask = 13'h1E00;
		endcase
	endfunction
endpackage

/* File: cs_channel_match.sv */
module cs_channel_match
	import chip_select_pkg::*;
(
	input wire logic [15:0] baseReg,
	input wire logic [15:0] optReg,
	input wire logic [23:0] busAddr,
	input wire logic busRead,
	input wire logic busUpper,
	input wire logic busLower,
	input wire logic [1:0] busSpace,
	input wire logic [2:0] busLevel,
	output logic hit
);
	logic [12:0] mask;
	logic addrOk, laneOk, dirOk, spaceOk, levelOk;
	logic [1:0] spaceOpt;
	logic [2:0] levelOpt;

	assign spaceOpt = optReg[SPACE_HI:SPACE_LO];
	assign levelOpt = optReg[LEVEL_HI:LEVEL_LO];
	assign mask = blockMask(baseReg[BLK_HI:BLK_LO]);
	assign addrOk = ((busAddr[23:11] ^ baseReg[BASE_HI:BASE_LO]) & mask) == 0;
	assign laneOk = (optReg[BYTE_LO] & busLower) | (optReg[BYTE_HI] & busUpper);
	// Reserved direction code 00 never matches
	assign dirOk = (optReg[RW_LO] & busRead) | (optReg[RW_HI] & ~busRead);
	assign spaceOk = (spaceOpt == busSpace) |
		(spaceOpt == SPACE_BOTH & (busSpace == SPACE_USER |
		busSpace == SPACE_SUPV));
	// Level only qualifies CPU-space acknowledge cycles; user and supervisor recognition untouched
	assign levelOk = busSpace != SPACE_CPU | levelOpt == LEVEL_ALL |
		levelOpt == busLevel;
	assign hit = addrOk & laneOk & dirOk & spaceOk & levelOk;
endmodule // cs_channel_match

/* File: cs_wait_timer.sv */
module cs_wait_timer
	import chip_select_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic start,
	input wire logic [3:0] waitCount,
	input wire logic cycleValid,
	output logic ackPulse
);
	typedef enum logic [2:0] {
		T_IDLE = 3'b001,
		T_COUNT = 3'b010,
		T_HOLD = 3'b100
	} timer_state_t;
	timer_state_t state_ff;
	logic [3:0] cnt_ff;

	assign ackPulse = state_ff == T_COUNT && cnt_ff == 4'h0;

	always_ff @(posedge clk) begin
		if (reset) begin
			state_ff <= T_IDLE;
		end else begin
			unique case (state_ff)
				T_IDLE: if (start) state_ff <= T_COUNT;
				T_COUNT: begin
					if (ackPulse) state_ff <= T_HOLD;
					else if (!cycleValid) state_ff <= T_IDLE;
				end
				T_HOLD: if (!cycleValid) state_ff <= T_IDLE;
				default: state_ff <= T_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) cnt_ff <= 4'h0;
		else if (start) cnt_ff <= waitCount;
		else if (state_ff == T_COUNT && cnt_ff != 4'h0) cnt_ff <= cnt_ff - 4'h1;
	end

	AST_WAIT_TWO: assert property (@(posedge clk) disable iff (reset)
		(start && state_ff == T_IDLE && waitCount == 4'h2) ##1
		cycleValid[*2] |=> ackPulse)
		else $error("two wait states did not end on the third cycle");
	COV_WAIT: cover property (@(posedge clk) disable iff (reset)
		ackPulse);
endmodule // cs_wait_timer

/* File: cs_memory_model.sv */
module cs_memory_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic [6:0] selectN,
	input wire logic [3:0] latency,
	output logic externalAck
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] count_ff;
	// Access time counts from the select; saturates so a stuck select holds ack
	always_ff @(posedge clk) begin
		if (reset || (&selectN)) begin
			count_ff <= 4'h0;
		end else if (count_ff != 4'hF) begin
			count_ff <= count_ff + 4'h1;
		end
	end
	// Ack released with the select, never left standing for the next cycle
	assign externalAck = !reset && !(&selectN) && (count_ff >= latency);
endmodule // cs_memory_model

/* File: chip_select_generator_test.sv */
module chip_select_generator_test;
	import chip_select_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, externalAck, bootSelectPinN;
	logic [23:0] busAddr = 24'h00_0000;
	logic busRead = 1'b0;
	logic busUpper = 1'b0;
	logic busLower = 1'b0;
	logic [1:0] busSpace = 2'h0;
	logic [2:0] busLevel = 3'h0;
	logic cycleValid = 1'b0;
	logic addrStrobe = 1'b0;
	logic dataStrobe = 1'b0;
	logic ePhaseClock = 1'b0;
	logic [13:0] lowAssign = 14'h0000;
	logic [STRAP_W-1:0] resetStrap = 5'h00;
	logic [NUM_LATCH-1:0] discreteOutputLatch = 4'h0;
	logic [5:0] lowSelectN;
	logic [NUM_HIGH-1:0] pinLevel;
	logic cycleAck, ackPort16, fastTerm, awaitExternal, autovector, syncCycle;
	logic [11:0] selVec;
	logic [31:0] rdv;
	logic [31:0] seedVal;
	logic errv;
	int failures = 0;
	int checked = 0;
	int lowTab[8] = '{11, 13, 14, 16, 17, 18, 19, 20};
	int ackTab[8] = '{0, 13, 14, 15, 1, 7, 12, 2};

	assign selVec = {pinLevel, lowSelectN, bootSelectPinN};
	always #50 clk = ~clk;
	always @(posedge clk) ePhaseClock <= ~ePhaseClock;

	chip_select_generator dut (.clk, .reset, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .busAddr, .busRead,
		.busUpper, .busLower, .busSpace, .busLevel, .cycleValid, .addrStrobe,
		.dataStrobe, .ePhaseClock, .externalAck, .lowAssign, .resetStrap,
		.discreteOutputLatch, .bootSelectPinN, .lowSelectN, .pinLevel,
		.cycleAck, .ackPort16, .fastTerm, .awaitExternal, .autovector,
		.syncCycle);

	cs_memory_model mem (.clk, .reset,
		.selectN({lowSelectN, bootSelectPinN}), .latency(4'h3), .externalAck);

	task automatic complete_run();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Entered just after a rising edge; leaves one idle cycle behind it
	task automatic apb(input logic wr, input logic [11:0] a,
			input logic [15:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {16'h0000, d};
		@(posedge clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		rdv = prdata;
		errv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k == 20) begin
			failures++;
			complete_run();
		end
		@(posedge clk);
	endtask

	function automatic logic expHit(input logic [15:0] b, o,
			input logic [23:0] a, input logic rd, up, lo, ds,
			input logic [1:0] sp, input logic [2:0] lv);
		logic [23:0] m;
		logic spOk;
		m = 24'hFF_FFFF << lowTab[b[2:0]];
		spOk = (o[5:4] == 2'h3) ? (sp == 2'h1 || sp == 2'h2) : (sp == o[5:4]);
		return (((a ^ {b[15:3], 11'h000}) & m) == 24'h00_0000)
			&& ((o[14] && up) || (o[13] && lo))
			&& (rd ? o[11] : o[12]) && spOk
			&& (sp != 2'h0 || o[3:1] == 3'h0 || o[3:1] == lv)
			&& (ds || !o[10]);
	endfunction

	task automatic busCycle(input int idx, input logic [1:0] pa,
			input logic [15:0] b, o, input logic [23:0] a,
			input logic rd, up, lo, ds, input logic [1:0] sp,
			input logic [2:0] lv);
		logic hit;
		int k;
		int ackAt;
		int wantAt;
		logic [11:0] off;
		off = (idx == 0) ? 12'h008 : 12'(16 + (idx - 1) * 8);
		if (idx > 6) apb(1'b1, 12'h000, 16'(pa) << (2 * (idx - 7)));
		else lowAssign[2 * idx +: 2] <= pa;
		apb(1'b1, off, b);
		apb(1'b1, off + 12'h004, o);
		hit = expHit(b, o, a, rd, up, lo, ds, sp, lv) && (pa[1] || idx == 0);
		wantAt = (!hit || o[15] || o[9:6] == 4'hF) ? -1 : (o[9:6] == 4'hE) ? 0
			: int'(o[9:6]) + 1;
		busAddr <= a;
		busRead <= rd;
		busUpper <= up;
		busLower <= lo;
		busSpace <= sp;
		busLevel <= lv;
		dataStrobe <= ds;
		addrStrobe <= 1'b1;
		cycleValid <= 1'b1;
		ackAt = -1;
		for (k = 0; k < 20; k++) begin
			@(negedge clk);
			if (cycleAck === 1'b1 && ackAt < 0) ackAt = k;
			if (k == 1) begin
				// Select saw the E phase level from before the last edge
				if (idx < 7 || pa[1])
					check(32'(selVec[idx]), 32'(!(hit && (!o[15] || !ePhaseClock))));
				check(32'(awaitExternal), 32'(hit && !o[15] && o[9:6] == 4'hF));
				check(32'(fastTerm), 32'(hit && !o[15] && o[9:6] == 4'hE));
				check(32'(syncCycle), 32'(hit && o[15]));
				check(32'(autovector), 32'(hit && sp == 2'h0 && o[0] && !o[15]));
				if (hit && pa[1]) check(32'(ackPort16), 32'(pa[0]));
			end
			@(posedge clk);
		end
		check(32'(ackAt), 32'(wantAt));
		cycleValid <= 1'b0;
		addrStrobe <= 1'b0;
		dataStrobe <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		if (idx < 7 || pa[1]) check(32'(selVec[idx]), 32'h0000_0001);
		@(posedge clk);
		apb(1'b1, off + 12'h004, 16'h0000);
	endtask

	initial begin
		int i;
		logic [31:0] e;
		logic [15:0] b, o;
		logic [23:0] a;
		seedVal = $urandom(32'h0000_ef03);
		resetStrap <= 5'($urandom);
		discreteOutputLatch <= 4'($urandom);
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		apb(1'b0, 12'h000, 16'h0000);
		e = 32'h0000_0000;
		for (i = 0; i < 5; i++) e[2 * i +: 2] = {resetStrap[i], 1'b1};
		check(rdv, e);
		apb(1'b0, 12'h008, 16'h0000);
		check(rdv, 32'h0000_0007);
		for (i = 0; i < 12; i++) begin
			apb(1'b0, 12'(12 + 8 * i), 16'h0000);
			check(rdv, 32'h0000_0000);
			if (i < 11) apb(1'b0, 12'(16 + 8 * i), 16'h0000);
			if (i < 11) check(rdv, 32'h0000_0000);
		end
		apb(1'b0, 12'h068, 16'h0000);
		check(32'(errv), 32'h0000_0001);
		$display("test reset_values done");
		apb(1'b1, 12'h000, 16'hFFFF);
		apb(1'b0, 12'h000, 16'h0000);
		check(rdv, 32'h0000_03FF);
		apb(1'b1, 12'h000, 16'h0155);
		busAddr <= 24'($urandom);
		repeat (3) @(posedge clk);
		@(negedge clk);
		check(32'(pinLevel), 32'(busAddr[23:19]));
		@(posedge clk);
		apb(1'b1, 12'h000, 16'h0000);
		repeat (3) @(posedge clk);
		@(negedge clk);
		check(32'(pinLevel[3:0]), 32'(discreteOutputLatch));
		@(posedge clk);
		$display("test pin_assign done");
		busCycle(0, 2'h0, 16'h0000, 16'h7830, 24'h00_0123, 1'b1, 1'b1, 1'b0,
			1'b0, 2'h1, 3'h0);
		for (i = 0; i < 8; i++) begin
			b = {13'($urandom), 3'(i)};
			o = 16'h7830 | 16'(ackTab[i] << 6);
			a = ({b[15:3], 11'h000} & (24'hFF_FFFF << lowTab[i]))
				+ 24'((1 << lowTab[i]) - 1);
			busCycle(1 + i % 6, {1'b1, i[0]}, b, o, a, i[1], 1'b1, 1'b1, 1'b0,
				2'h2, 3'h0);
			busCycle(7 + i % 5, {1'b1, i[0]}, b, o, a + 24'h00_0001, 1'b0,
				1'b1, 1'b0, 1'b1, 2'h1, 3'h0);
		end
		$display("test block_sizes done");
		for (i = 0; i < 100; i++) begin
			b = 16'($urandom);
			o = 16'($urandom);
			if (o[15]) o[0] = 1'b0;
			a = {b[15:3], 11'h000} ^ (24'($urandom) >> ($urandom % 24));
			busCycle($urandom % 12, 2'($urandom), b, o, a, 1'($urandom),
				1'($urandom), 1'($urandom), 1'($urandom), 2'($urandom % 3),
				3'($urandom));
		end
		$display("test random_cycles done");
		complete_run();
	end
endmodule // chip_select_generator_test
